//--- rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [7:0] IDX_RESULT_LOW = 8'h20;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h21;
    localparam logic [7:0] IDX_CONTROL = 8'h22;
    localparam logic [7:0] IDX_CLOCK_SELECT = 8'h23;
    localparam logic [7:0] IDX_IRQ = 8'h24;

    localparam int ADDR_W = 10;

    // Control register fields.
    localparam int CTL_CHAN_LSB = 0;
    localparam int CTL_PINCFG_LSB = 3;
    localparam int CTL_DONE_N_BIT = 6;
    localparam int CTL_START_BIT = 7;

    // Clock select fields.
    localparam int CLK_DIV_LSB = 0;
    localparam int CLK_TEST_BIT = 7;

    // Interrupt register fields.
    localparam int IRQ_ENABLE_BIT = 0;
    localparam int IRQ_FLAG_BIT = 1;

    localparam logic [7:0] CONTROL_RESET = 8'h40;
    localparam logic [7:0] CLOCK_SELECT_RESET = 8'h80;

    // Converter clock divide codes and their ratios.
    localparam logic [1:0] DIV_CODE_2 = 2'h0;
    localparam logic [1:0] DIV_CODE_8 = 2'h1;
    localparam logic [1:0] DIV_CODE_32 = 2'h2;
    localparam logic [5:0] DIV_RATIO_2 = 6'h02;
    localparam logic [5:0] DIV_RATIO_8 = 6'h08;
    localparam logic [5:0] DIV_RATIO_32 = 6'h20;

    localparam int RESULT_W = 9;
    localparam int CONV_PERIODS = 16;
    localparam int SAMPLE_PERIODS = 4;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SAMPLE,
        SEQ_DECIDE,
        SEQ_HOLD
    } seq_state_t;

    typedef struct packed {
        logic power_on;
        logic core_reset;
        logic sample;
        logic [1:0] mux_sel;
        logic [RESULT_W-1:0] dac_code;
    } analog_ctrl_t;

endpackage

//--- rtl/conv_clock_divider.sv
`timescale 1ns/1ps
module conv_clock_divider (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic [1:0] div_code,
    output logic tick
);
    import adc_ctrl_pkg::*;

    logic [5:0] count_r;
    logic [5:0] ratio;

    // Code 11 is undefined; it runs at the slowest rate so nothing overclocks the core.
    always_comb begin
        case (div_code)
            DIV_CODE_2: ratio = DIV_RATIO_2;
            DIV_CODE_8: ratio = DIV_RATIO_8;
            DIV_CODE_32: ratio = DIV_RATIO_32;
            default: ratio = DIV_RATIO_32;
        endcase
    end

    assign tick = (count_r >= ratio - 6'h01);

    always_ff @(posedge ref_clk) begin
        if (reset || clear || tick) begin
            count_r <= 6'h00;
        end else begin
            count_r <= count_r + 6'h01;
        end
    end

endmodule

//--- rtl/sar_sequencer.sv
`timescale 1ns/1ps
module sar_sequencer #(
    parameter int CONV_TICKS = adc_ctrl_pkg::CONV_PERIODS,
    parameter int SAMPLE_TICKS = adc_ctrl_pkg::SAMPLE_PERIODS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic abort,
    input wire logic launch,
    input wire logic tick,
    input wire logic cmp_high,
    output logic busy,
    output logic sample,
    output logic done,
    output logic [adc_ctrl_pkg::RESULT_W-1:0] dac_code,
    output logic [adc_ctrl_pkg::RESULT_W-1:0] result
);
    import adc_ctrl_pkg::*;

    seq_state_t state_r;
    logic [7:0] ticks_r;
    logic [3:0] bit_r;
    logic [RESULT_W-1:0] code_r;

    assign busy = (state_r != SEQ_IDLE);
    assign sample = (state_r == SEQ_SAMPLE);
    assign dac_code = code_r;
    assign done = (state_r == SEQ_HOLD) && tick && (ticks_r == 8'(CONV_TICKS - 1));

    always_ff @(posedge ref_clk) begin
        if (reset || abort) begin
            state_r <= SEQ_IDLE;
            ticks_r <= 8'h00;
            bit_r <= 4'h0;
            code_r <= '0;
        end else begin
            if (tick && busy) begin
                ticks_r <= ticks_r + 8'h01;
            end
            case (state_r)
                SEQ_IDLE: begin
                    if (launch) begin
                        state_r <= SEQ_SAMPLE;
                        ticks_r <= 8'h00;
                        code_r <= '0;
                    end
                end
                SEQ_SAMPLE: begin
                    if (tick && ticks_r == 8'(SAMPLE_TICKS - 1)) begin
                        state_r <= SEQ_DECIDE;
                        bit_r <= 4'(RESULT_W - 1);
                        code_r <= {1'b1, {(RESULT_W-1){1'b0}}};
                    end
                end
                SEQ_DECIDE: begin
                    if (tick) begin
                        // The trial bit stays only while the input is at or above the trial level.
                        if (!cmp_high) begin
                            code_r[bit_r] <= 1'b0;
                        end
                        if (bit_r == 4'h0) begin
                            state_r <= SEQ_HOLD;
                        end else begin
                            bit_r <= bit_r - 4'h1;
                            code_r[bit_r - 4'h1] <= 1'b1;
                        end
                    end
                end
                SEQ_HOLD: begin
                    if (done) begin
                        state_r <= SEQ_IDLE;
                    end
                end
                default: state_r <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            result <= '0;
        end else if (done) begin
            result <= code_r;
        end
    end

endmodule

//--- rtl/adc_conversion_control.sv
// Operation
// - Start rising resets converter and sets done flag; start falling launches conversion.
// - Finished conversion clears done flag bit 6 and sets interrupt request flag.
// - Control bits 2..0 pick analog input 0..3; codes with bit 2 unusable.
// - Control bits 5..3 choose how many port B lines are analog.
// - Analog lines lose digital function and pull-high; converter powers on.
// - Result bits 8..1 in high byte, bit 0 in low byte bit 7.
// - Result bytes are read-only; writes leave the result alone.
// - Clock select bits 1..0 divide the core clock by 2, 8 or 32.
`timescale 1ns/1ps
module adc_conversion_control #(
    parameter int CONV_TICKS = adc_ctrl_pkg::CONV_PERIODS,
    parameter int SAMPLE_TICKS = adc_ctrl_pkg::SAMPLE_PERIODS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_async,
    input wire logic irq_service_ack,
    output adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
    output logic [3:0] port_b_analog,
    output logic adc_irq
);
    import adc_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    // Thermometer mask of port B lines taken over by the converter.
    function automatic logic [3:0] analog_mask(input logic [2:0] cfg);
        case (cfg)
            3'h0: analog_mask = 4'h0;
            3'h1: analog_mask = 4'h1;
            3'h2: analog_mask = 4'h3;
            3'h3: analog_mask = 4'h7;
            default: analog_mask = 4'hF;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    logic [2:0] channel_sel_r;
    logic [2:0] analog_pin_cfg_r;
    logic start_r;
    logic start_prev_r;
    logic conversion_done_n_r;
    logic [1:0] conv_clock_div_r;
    logic test_bit_r;
    logic irq_enable_r;
    logic irq_flag_r;
    logic cmp_meta_r;
    logic cmp_sync_r;

    logic access;
    logic wr_access;
    logic hit_low;
    logic hit_high;
    logic hit_ctl;
    logic hit_clk;
    logic hit_irq;
    logic start_rise;
    logic start_fall;
    logic converter_power;
    logic conv_abort;
    logic tick;
    logic seq_busy;
    logic seq_sample;
    logic seq_done;
    logic [RESULT_W-1:0] seq_dac;
    logic [RESULT_W-1:0] seq_result;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave. Every access completes in its first access cycle.

    assign access = psel && penable;
    assign wr_access = access && pwrite;
    assign hit_low = (paddr == byte_addr(IDX_RESULT_LOW));
    assign hit_high = (paddr == byte_addr(IDX_RESULT_HIGH));
    assign hit_ctl = (paddr == byte_addr(IDX_CONTROL));
    assign hit_clk = (paddr == byte_addr(IDX_CLOCK_SELECT));
    assign hit_irq = (paddr == byte_addr(IDX_IRQ));

    assign pready = access;
    assign pslverr = access && !(hit_low || hit_high || hit_ctl || hit_clk || hit_irq);

    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            if (hit_low) begin
                prdata[7] = seq_result[0];
            end else if (hit_high) begin
                prdata[7:0] = seq_result[RESULT_W-1:1];
            end else if (hit_ctl) begin
                prdata[7:0] = {start_r, conversion_done_n_r, analog_pin_cfg_r, channel_sel_r};
            end else if (hit_clk) begin
                // Bits 6..2 have no storage behind them.
                prdata[7:0] = {test_bit_r, 5'h00, conv_clock_div_r};
            end else if (hit_irq) begin
                prdata[IRQ_FLAG_BIT] = irq_flag_r;
                prdata[IRQ_ENABLE_BIT] = irq_enable_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register. The done flag is owned by hardware and ignores writes.

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            channel_sel_r <= CONTROL_RESET[CTL_CHAN_LSB +: 3];
            analog_pin_cfg_r <= CONTROL_RESET[CTL_PINCFG_LSB +: 3];
            start_r <= CONTROL_RESET[CTL_START_BIT];
        end else if (wr_access && hit_ctl) begin
            channel_sel_r <= pwdata[CTL_CHAN_LSB +: 3];
            analog_pin_cfg_r <= pwdata[CTL_PINCFG_LSB +: 3];
            start_r <= pwdata[CTL_START_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            start_prev_r <= CONTROL_RESET[CTL_START_BIT];
        end else begin
            start_prev_r <= start_r;
        end
    end

    assign start_rise = start_r && !start_prev_r;
    assign start_fall = !start_r && start_prev_r;

    // A powered-down converter cannot finish, so an active conversion is dropped.
    // Software then re-initialises with a start pulse after powering up.
    assign conv_abort = start_rise || !converter_power;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            conversion_done_n_r <= CONTROL_RESET[CTL_DONE_N_BIT];
        end else if (start_rise) begin
            conversion_done_n_r <= 1'b1;
        end else if (seq_done) begin
            conversion_done_n_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock select register. Bit 7 is stored only so it reads back.

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            conv_clock_div_r <= CLOCK_SELECT_RESET[CLK_DIV_LSB +: 2];
            test_bit_r <= CLOCK_SELECT_RESET[CLK_TEST_BIT];
        end else if (wr_access && hit_clk) begin
            conv_clock_div_r <= pwdata[CLK_DIV_LSB +: 2];
            test_bit_r <= pwdata[CLK_TEST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt request. A completion in the same cycle as a clear keeps the flag.

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_enable_r <= 1'b0;
        end else if (wr_access && hit_irq) begin
            irq_enable_r <= pwdata[IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_flag_r <= 1'b0;
        end else if (seq_done) begin
            irq_flag_r <= 1'b1;
        end else if (irq_service_ack || (wr_access && hit_irq && pwdata[IRQ_FLAG_BIT])) begin
            irq_flag_r <= 1'b0;
        end
    end

    assign adc_irq = irq_flag_r && irq_enable_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator from the analog core is asynchronous to this clock.

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            cmp_meta_r <= cmp_async;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Converter clock and successive approximation.

    // Restarting the divider on launch makes every conversion the same length.
    conv_clock_divider u_divider (
        .ref_clk(ref_clk),
        .reset(reset),
        .clear(!seq_busy),
        .div_code(conv_clock_div_r),
        .tick(tick)
    );

    // The result register is written only by a completed conversion.
    sar_sequencer #(
        .CONV_TICKS(CONV_TICKS),
        .SAMPLE_TICKS(SAMPLE_TICKS)
    ) u_sequencer (
        .ref_clk(ref_clk),
        .reset(reset),
        .abort(conv_abort),
        .launch(start_fall && converter_power),
        .tick(tick),
        .cmp_high(cmp_sync_r),
        .busy(seq_busy),
        .sample(seq_sample),
        .done(seq_done),
        .dac_code(seq_dac),
        .result(seq_result)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Analog side and port B takeover.

    assign port_b_analog = analog_mask(analog_pin_cfg_r);
    assign converter_power = (analog_pin_cfg_r != 3'h0);

    always_comb begin
        analog_ctrl.power_on = converter_power;
        analog_ctrl.core_reset = start_r;
        analog_ctrl.sample = seq_sample;
        // Codes with bit 2 set are unusable; only the low two bits reach the mux.
        analog_ctrl.mux_sel = channel_sel_r[1:0];
        analog_ctrl.dac_code = seq_dac;
    end

endmodule

//--- verif/adc_ctrl_props.sv
`timescale 1ns/1ps
module adc_ctrl_props
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_TICKS = adc_ctrl_pkg::CONV_PERIODS,
    parameter int SAMPLE_TICKS = adc_ctrl_pkg::SAMPLE_PERIODS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic cmp_async,
    input wire logic irq_service_ack,
    input wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
    input wire logic [3:0] port_b_analog,
    input wire logic adc_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic acc;
    logic [7:0] ctl_r;
    assign acc = psel && penable;

    // Shadow of the control byte, so pin and mux outputs can be tied to what was written.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctl_r <= CONTROL_RESET;
        end else if (acc && pwrite && paddr == {IDX_CONTROL, 2'b00}) begin
            ctl_r <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////
    a_pin_mask: assert property (
        port_b_analog == (ctl_r[5] ? 4'hF : 4'hF >> (3'd4 - {1'b0, ctl_r[4:3]})))
        else $error("port b analog mask wrong");
    a_power_follow: assert property (
        analog_ctrl.power_on == (ctl_r[5:3] != 3'h0))
        else $error("converter power wrong");
    a_mux_follow: assert property (
        analog_ctrl.mux_sel == ctl_r[1:0])
        else $error("channel select wrong");
    a_start_level: assert property (
        analog_ctrl.core_reset == ctl_r[7])
        else $error("converter reset not start level");
    a_start_holds: assert property (
        analog_ctrl.core_reset [*2] |-> !analog_ctrl.sample)
        else $error("sampling while start held");
    a_ctl_read: assert property (
        acc && !pwrite && paddr == {IDX_CONTROL, 2'b00}
        |-> prdata[7] == ctl_r[7] && prdata[5:0] == ctl_r[5:0] && prdata[31:8] == 24'h0)
        else $error("control readback wrong");
    a_unused_zero: assert property (
        acc && !pwrite && paddr == {IDX_CLOCK_SELECT, 2'b00} |-> prdata[6:2] == 5'h0)
        else $error("clock select unused bits set");
    a_irq_holds: assert property (
        adc_irq && !irq_service_ack && !(acc && pwrite && paddr == {IDX_IRQ, 2'b00}) |=> adc_irq)
        else $error("interrupt dropped by itself");

    c_irq: cover property ($rose(adc_irq));
    c_err: cover property (acc && pslverr);
    c_sample: cover property (analog_ctrl.sample ##1 !analog_ctrl.sample);
endmodule

bind adc_conversion_control adc_ctrl_props #(
    .CONV_TICKS(CONV_TICKS),
    .SAMPLE_TICKS(SAMPLE_TICKS)
) u_props (
    .ref_clk(ref_clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cmp_async(cmp_async),
    .irq_service_ack(irq_service_ack),
    .analog_ctrl(analog_ctrl),
    .port_b_analog(port_b_analog),
    .adc_irq(adc_irq)
);

//--- verif/analog_core_model.sv
`timescale 1ns/1ps
module analog_core_model
    import adc_ctrl_pkg::*;
(
    input wire logic ref_clk,
    input wire adc_ctrl_pkg::analog_ctrl_t analog_ctrl,
    input wire logic [3:0][8:0] vin,
    output logic cmp_async
);
    logic [8:0] held_r;
    logic idle_r = 1'b0;

    always_ff @(posedge ref_clk) begin
        if (analog_ctrl.sample) begin
            held_r <= vin[analog_ctrl.mux_sel];
        end
    end

    // A powered-down comparator gives no trustworthy level, so it toggles.
    always_ff @(posedge ref_clk) begin
        idle_r <= ~idle_r;
    end

    assign cmp_async = analog_ctrl.power_on ? (held_r >= analog_ctrl.dac_code) : idle_r;
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    import adc_ctrl_pkg::*;
    // Sample plus nine decisions plus at least one hold period: CT must exceed SAMPLE_TICKS + 9.
    localparam int CT = 12;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmp_async;
    logic irq_service_ack = 1'b0;
    analog_ctrl_t analog_ctrl;
    logic [3:0] port_b_analog;
    logic adc_irq;
    logic [3:0][8:0] vin = '0;
    logic [31:0] rdat;
    logic [31:0] r0;
    logic rerr;
    logic [1:0] dv;
    logic [1:0] ch;
    logic [2:0] cf;
    int n;
    int ex;
    int fail_count = 0;
    int tests_run = 0;

    always #2.5 ref_clk = ~ref_clk;

    adc_conversion_control #(.CONV_TICKS(CT), .SAMPLE_TICKS(1)) u_dut (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_async(cmp_async), .irq_service_ack(irq_service_ack), .analog_ctrl(analog_ctrl),
        .port_b_analog(port_b_analog), .adc_irq(adc_irq));
    analog_core_model u_core (.ref_clk(ref_clk), .analog_ctrl(analog_ctrl), .vin(vin), .cmp_async(cmp_async));

    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [3:0] pin_mask(logic [2:0] c);
        return c[2] ? 4'hF : 4'hF >> (3'd4 - {1'b0, c[1:0]});
    endfunction

    function automatic logic [31:0] res_byte(logic hi, logic [8:0] v);
        return hi ? {24'h0, v[8:1]} : {24'h0, v[0], 7'h0};
    endfunction

    task automatic start_conv(input logic [7:0] c);
        apb(1'b1, IDX_CONTROL, c | 8'h80);
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk("done flag set", 32'h1, {31'h0, rdat[6]});
        apb(1'b1, IDX_CONTROL, c);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        #(5 * 40000);
        fail_count++;
        $display("Error watchdog expected finish seen timeout");
        give_verdict;
    end

    initial begin
        void'($urandom(32'h863F));
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk("control reset", {24'h0, CONTROL_RESET}, rdat);
        apb(1'b0, IDX_CLOCK_SELECT, 8'h00);
        chk("clock reset", {24'h0, CLOCK_SELECT_RESET}, rdat);
        apb(1'b1, IDX_CLOCK_SELECT, 8'hFE);
        apb(1'b0, IDX_CLOCK_SELECT, 8'h00);
        chk("clock unused", 32'h82, rdat);
        apb(1'b0, 8'h30, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            dv = (i < 4) ? 2'(i) : 2'($urandom % 3);
            ch = 2'($urandom % 4);
            cf = 3'(ch + 1 + $urandom % (7 - ch));
            vin <= 36'({$urandom, $urandom});
            apb(1'b1, IDX_CLOCK_SELECT, {6'h20, dv});
            apb(1'b1, IDX_IRQ, 8'h03);
            apb(1'b1, IDX_CONTROL, {2'h0, cf, 1'b0, ch});
            // Register outputs move at the write edge itself, so look half a cycle later.
            @(negedge ref_clk);
            chk("pin mask", {28'h0, pin_mask(cf)}, {28'h0, port_b_analog});
            start_conv({2'h0, cf, 1'b0, ch});
            if (i == 1) begin
                repeat (6) @(posedge ref_clk);
                start_conv({2'h0, cf, 1'b0, ch});
            end
            n = 0;
            while (adc_irq !== 1'b1 && n < 2000) begin
                @(posedge ref_clk);
                n++;
            end
            ex = (dv == 0) ? 2 : (dv == 1) ? 8 : 32;
            chk("conversion length", 32'h1, {31'h0, n >= CT * ex - ex && n <= CT * ex + ex + 4});
            apb(1'b0, IDX_CONTROL, 8'h00);
            chk("done flag clear", 32'h0, {31'h0, rdat[6]});
            for (int b = 0; b < 2; b++) begin
                apb(1'b0, 8'(IDX_RESULT_LOW + b), 8'h00);
                r0 = rdat;
                apb(1'b1, 8'(IDX_RESULT_LOW + b), 8'($urandom));
                apb(1'b0, 8'(IDX_RESULT_LOW + b), 8'h00);
                chk("result kept", r0, rdat);
                if (dv != 0) begin
                    chk("result byte", res_byte(b[0], vin[ch]), rdat & (b ? 32'hFF : 32'h80));
                end
            end
            chk("irq raised", 32'h1, {31'h0, adc_irq});
            apb(1'b1, IDX_IRQ, 8'h00);
            @(negedge ref_clk);
            chk("irq masked", 32'h0, {31'h0, adc_irq});
            apb(1'b0, IDX_IRQ, 8'h00);
            chk("irq flag kept", 32'h2, rdat);
            if (i % 2 == 1) begin
                @(posedge ref_clk);
                irq_service_ack <= 1'b1;
                @(posedge ref_clk);
                irq_service_ack <= 1'b0;
            end else begin
                apb(1'b1, IDX_IRQ, 8'h02);
            end
            apb(1'b0, IDX_IRQ, 8'h00);
            chk("irq flag cleared", 32'h0, rdat);
            $display("test conversion %0d done", i);
        end
        apb(1'b1, IDX_CONTROL, 8'h01);
        @(negedge ref_clk);
        chk("power off", 32'h0, {27'h0, analog_ctrl.power_on, port_b_analog});
        start_conv(8'h01);
        repeat (CT * 64) @(posedge ref_clk);
        apb(1'b0, IDX_CONTROL, 8'h00);
        chk("no launch", 32'h1, {31'h0, rdat[6]});
        $display("test power off done");
        give_verdict;
    end
endmodule
